// *** design/toc_pkg.sv ***
/*
  toc_pkg: constants and carrier types for the trip output contact logic.
  Assumes a 100 MHz system clock; every timing count derives from it here.
*/
package toc_pkg;
  localparam int TOC_NUM_ELEM = 9;
  localparam int TOC_NUM_OUT = 6;
  localparam int TOC_NUM_FUNC = 16;
  localparam int TOC_NUM_PIN = 6;
  // element bit positions in the element flag vector
  localparam int TOC_EL_PH_TOC = 0;
  localparam int TOC_EL_GND_TOC = 1;
  localparam int TOC_EL_PH_INST_LOW = 2;
  localparam int TOC_EL_PH_INST_MID = 3;
  localparam int TOC_EL_PH_INST_HIGH = 4;
  localparam int TOC_EL_GND_INST_LOW = 5;
  localparam int TOC_EL_GND_INST_MID = 6;
  localparam int TOC_EL_GND_INST_HIGH = 7;
  localparam int TOC_EL_NEG_SEQ = 8;
  // reset values of configuration held in flops
  localparam logic [TOC_NUM_ELEM-1:0] TOC_MASK_RST = 9'h1FF;
  // timing: clock, power cycle, delay step, delay range
  localparam int TOC_CLK_HZ = 100_000_000;
  localparam int TOC_LINE_HZ = 60;
  localparam int TOC_POWER_CYCLES = 3;
  localparam int TOC_CYC_PER_POWER = TOC_CLK_HZ / TOC_LINE_HZ;
  localparam int TOC_STEP_MS = 10;
  localparam int TOC_CYC_PER_STEP = TOC_CLK_HZ / 1000 * TOC_STEP_MS;
  localparam int TOC_DELAY_MAX_S = 250;
  localparam int TOC_DELAY_MAX_STEPS = TOC_DELAY_MAX_S * 1000 / TOC_STEP_MS;
  localparam int TOC_DELAY_W = 15;
  localparam logic [1:0] TOC_SYNC_RST = 2'h0;

  // current-level comparisons supplied by the metering logic
  typedef struct packed {
    logic below_5pct;         // below 5 percent of time overcurrent pickups
    logic [2:0] phase_le_90;  // per phase at or below 90 percent of lowest pickup
  } toc_current_t;

  // breaker auxiliary contact states, already conditioned
  typedef struct packed {
    logic breaker_closed_aux;
    logic breaker_open_aux;
  } toc_breaker_t;

  // per-output configuration
  typedef struct packed {
    logic [TOC_NUM_FUNC-1:0] map;
    logic use_and;                 // 0 selects OR
    logic norm_closed;
    logic [TOC_DELAY_W-1:0] delay; // in 10 ms steps
  } toc_out_cfg_t;

  typedef enum logic [1:0] {
    TOC_ST_IDLE = 2'b00,
    TOC_ST_SEALED = 2'b01,
    TOC_ST_MDT_WAIT = 2'b10
  } toc_trip_st_t;
endpackage

// *** design/toc_prog_out.sv ***
/*
  toc_prog_out: one programmable output, mapping, combining, delay, polarity.
  Assumes i_tick is a one-cycle 10 ms enable and functions are synchronous.
*/
`timescale 1ns/1ps
module toc_prog_out (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [toc_pkg::TOC_NUM_FUNC-1:0] i_func,
  input wire toc_pkg::toc_out_cfg_t i_cfg,
  output logic o_contact
);
  logic cond;
  logic [toc_pkg::TOC_DELAY_W-1:0] count;
  logic active;

  // an empty map never operates, even in AND mode
  always_comb begin
    if (i_cfg.map == '0) begin
      cond = 1'b0;
    end else if (i_cfg.use_and) begin
      cond = &(i_func | ~i_cfg.map);
    end else begin
      cond = |(i_func & i_cfg.map);
    end
  end

  // delay counts 10 ms ticks; a drop restarts it from zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= '0;
      active <= 1'b0;
    end else if (!cond) begin
      count <= '0;
      active <= 1'b0;
    end else if (count >= i_cfg.delay) begin
      active <= 1'b1;
    end else if (i_tick) begin
      count <= count + 1'b1;
    end
  end

  // polarity applied last so the contact flop is the output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_contact <= 1'b0;
    end else begin
      o_contact <= active ^ i_cfg.norm_closed;
    end
  end
endmodule // toc_prog_out

// *** design/toc_sync.sv ***
/*
  toc_sync: two-flop synchroniser vector for pins entering the clock domain.
  Assumes pins are static long enough to be sampled; no debounce here.
*/
`timescale 1ns/1ps
module toc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // toc_sync

// *** design/toc_top.sv ***
/*
  toc_top: master trip seal-in, self-check alarm pair, input pins and six
  programmable outputs of a feeder protection relay.
  Assumes element flags, current comparisons and power-health come from
  logic on i_clk; pins and breaker contacts are asynchronous and are
  synchronised here. Configuration ports are held static by software.
*/
`timescale 1ns/1ps
module toc_top #(
  parameter int CYC_PER_POWER = toc_pkg::TOC_CYC_PER_POWER,
  parameter int CYC_PER_STEP = toc_pkg::TOC_CYC_PER_STEP
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [toc_pkg::TOC_NUM_ELEM-1:0] i_elem_flags,
  input wire logic [toc_pkg::TOC_NUM_ELEM-1:0] i_elem_mask,
  input wire logic i_mask_load,
  input wire toc_pkg::toc_current_t i_current,
  input wire toc_pkg::toc_breaker_t i_breaker,
  input wire logic i_multi_dev_mode,
  input wire logic i_trip_polarity_jumper,
  input wire logic i_power_ok,
  input wire logic i_selftest_fail,
  input wire logic [toc_pkg::TOC_NUM_PIN-1:0] i_pin_pos,
  input wire logic i_pin6_neg,
  input wire logic [toc_pkg::TOC_NUM_PIN-1:0] i_func_enable_logic,
  input wire logic [toc_pkg::TOC_NUM_FUNC-1:0] i_func,
  input wire toc_pkg::toc_out_cfg_t [toc_pkg::TOC_NUM_OUT-1:0] i_out_cfg,
  output logic o_trip_contact,
  output logic o_trip_active,
  output logic o_open_interval_start,
  output logic o_alarm_no,
  output logic o_alarm_nc,
  output logic [toc_pkg::TOC_NUM_PIN-1:0] o_phys_in,
  output logic [toc_pkg::TOC_NUM_PIN-1:0] o_func_enable,
  output logic [toc_pkg::TOC_NUM_OUT-1:0] o_out_contact
);
  logic [toc_pkg::TOC_NUM_ELEM-1:0] mask;
  logic [1:0] brk_sync;
  logic [toc_pkg::TOC_NUM_PIN:0] pin_sync;
  logic jumper_sync;
  toc_pkg::toc_trip_st_t state;
  toc_pkg::toc_trip_st_t next_state;
  logic trip_req;
  logic all_below_90;
  logic breaker_open;
  logic [31:0] mdt_count;
  logic mdt_done;
  logic oc_tripped;
  logic [31:0] step_count;
  logic step_tick;

  // returns 1 when every phase sits at or below the dropout level
  function automatic logic all_low(input logic [2:0] ph);
    all_low = &ph;
  endfunction

  // breaker contacts and jumper are pins: two flops before use
  toc_sync #(.W(2)) u_brk_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_breaker.breaker_closed_aux, i_breaker.breaker_open_aux}),
    .o_q(brk_sync)
  );

  toc_sync #(.W(toc_pkg::TOC_NUM_PIN + 1)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_pin6_neg, i_pin_pos}),
    .o_q(pin_sync)
  );

  toc_sync #(.W(1)) u_jmp_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(i_trip_polarity_jumper),
    .o_q(jumper_sync)
  );

  // element mask, all enabled after reset, loaded on strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask <= toc_pkg::TOC_MASK_RST;
    end else if (i_mask_load) begin
      mask <= i_elem_mask;
    end
  end

  // trip request and release qualifiers
  assign trip_req = |(i_elem_flags & mask);
  assign all_below_90 = all_low(i_current.phase_le_90);
  // breaker open: closed-aux dropped and open-aux picked up
  assign breaker_open = ~brk_sync[1] & brk_sync[0];

  // next state of the seal-in; a fresh trip always wins over release
  always_comb begin
    next_state = state;
    unique case (state)
      toc_pkg::TOC_ST_IDLE: begin
        if (trip_req) begin
          next_state = toc_pkg::TOC_ST_SEALED;
        end
      end
      toc_pkg::TOC_ST_SEALED: begin
        if (trip_req) begin
          next_state = toc_pkg::TOC_ST_SEALED;
        end else if (i_multi_dev_mode) begin
          if (all_below_90) begin
            next_state = toc_pkg::TOC_ST_MDT_WAIT;
          end
        end else if (all_below_90 && i_current.below_5pct && breaker_open) begin
          next_state = toc_pkg::TOC_ST_IDLE;
        end
      end
      toc_pkg::TOC_ST_MDT_WAIT: begin
        if (trip_req || !all_below_90) begin
          next_state = toc_pkg::TOC_ST_SEALED;
        end else if (mdt_done) begin
          next_state = toc_pkg::TOC_ST_IDLE;
        end
      end
      default: begin
        next_state = toc_pkg::TOC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= toc_pkg::TOC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // three power cycles of low current, breaker contacts ignored
  assign mdt_done = (mdt_count >= toc_pkg::TOC_POWER_CYCLES * CYC_PER_POWER - 1);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mdt_count <= '0;
    end else if (state != toc_pkg::TOC_ST_MDT_WAIT) begin
      mdt_count <= '0;
    end else if (!mdt_done) begin
      mdt_count <= mdt_count + 32'h1;
    end
  end

  // remember an overcurrent caused the trip, for the open interval start
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oc_tripped <= 1'b0;
      o_open_interval_start <= 1'b0;
    end else begin
      o_open_interval_start <= 1'b0;
      if (trip_req) begin
        oc_tripped <= 1'b1;
      end else if (i_multi_dev_mode && oc_tripped && all_below_90) begin
        oc_tripped <= 1'b0;
        o_open_interval_start <= 1'b1;
      end else if (!i_multi_dev_mode && state == toc_pkg::TOC_ST_IDLE) begin
        oc_tripped <= 1'b0; // normal mode sequencing uses breaker status
      end
    end
  end

  // contact drive; jumper picks normally closed when high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_trip_active <= 1'b0;
      o_trip_contact <= 1'b0;
    end else begin
      o_trip_active <= (next_state != toc_pkg::TOC_ST_IDLE);
      o_trip_contact <= (next_state != toc_pkg::TOC_ST_IDLE) ^ jumper_sync;
    end
  end

  // alarm relay energised only while healthy; loss opens the NO contact and closes the NC contact
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alarm_no <= 1'b0;
      o_alarm_nc <= 1'b1;
    end else begin
      o_alarm_no <= i_power_ok & ~i_selftest_fail;
      o_alarm_nc <= ~(i_power_ok & ~i_selftest_fail);
    end
  end

  // physical inputs: five single-ended, sixth needs both terminals
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_phys_in <= '0;
    end else begin
      o_phys_in[4:0] <= pin_sync[4:0];
      o_phys_in[5] <= pin_sync[5] & pin_sync[6];
    end
  end

  // function enables follow their evaluated logical input
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_func_enable <= '0;
    end else begin
      o_func_enable <= i_func_enable_logic;
    end
  end

  // 10 ms tick shared by all output timers, cheaper than six prescalers
  assign step_tick = (step_count == CYC_PER_STEP - 1);
  always_ff @(posedge i_clk) begin
    if (i_rst || step_tick) begin
      step_count <= '0;
    end else begin
      step_count <= step_count + 32'h1;
    end
  end

  // six programmable outputs
  generate
    for (genvar g = 0; g < toc_pkg::TOC_NUM_OUT; g++) begin : g_out
      toc_prog_out u_out (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_tick(step_tick),
        .i_func(i_func),
        .i_cfg(i_out_cfg[g]),
        .o_contact(o_out_contact[g])
      );
    end
  endgenerate
endmodule // toc_top

// *** verif/toc_breaker_model.sv ***
/*
  toc_breaker_model: breaker mechanism with trip coil and aux contacts.
  Assumes the coil follows the trip seal-in and close is a one-cycle pulse.
*/
`timescale 1ns/1ps
module toc_breaker_model (
  input wire logic i_clk,
  input wire logic i_coil,
  input wire logic i_stall,
  input wire logic i_close,
  output toc_pkg::toc_breaker_t o_aux
);
  int travel = 0;
  // travel only while the coil is energised; a stall models a stuck mechanism
  always_ff @(posedge i_clk) begin
    if (i_close) travel <= 0;
    else if (i_coil && !i_stall && travel < 8) travel <= travel + 1;
  end
  // closed aux breaks two cycles before open aux makes, as in real travel
  assign o_aux.breaker_closed_aux = travel < 5;
  assign o_aux.breaker_open_aux = travel > 6;
endmodule // toc_breaker_model

// *** verif/toc_top_tb.sv ***
/*
  toc_top_tb: random and corner tests of the trip output contact logic.
  Assumes short power-cycle and delay-step counts and the breaker model.
*/
`timescale 1ns/1ps
module toc_top_tb;
  localparam int CPP = 10;
  logic clk, rst, load, mdt, jmp, pok, stf, neg, stall, cls, seen, nc, tr_c, tr_a, oi;
  logic a_no, a_nc;
  logic [8:0] flags, mask;
  logic [5:0] pins, fel, phys, fen, outc;
  logic [15:0] func, m, hv, mv;
  toc_pkg::toc_current_t cur;
  toc_pkg::toc_breaker_t brk;
  toc_pkg::toc_out_cfg_t [5:0] cfg;
  int err_count, check_count, fall;
  toc_top #(.CYC_PER_POWER(CPP), .CYC_PER_STEP(4)) DUT (.i_clk(clk), .i_rst(rst),
    .i_elem_flags(flags), .i_elem_mask(mask), .i_mask_load(load), .i_current(cur),
    .i_breaker(brk), .i_multi_dev_mode(mdt), .i_trip_polarity_jumper(jmp),
    .i_power_ok(pok), .i_selftest_fail(stf), .i_pin_pos(pins), .i_pin6_neg(neg),
    .i_func_enable_logic(fel), .i_func(func), .i_out_cfg(cfg), .o_trip_contact(tr_c),
    .o_trip_active(tr_a), .o_open_interval_start(oi), .o_alarm_no(a_no),
    .o_alarm_nc(a_nc), .o_phys_in(phys), .o_func_enable(fen), .o_out_contact(outc));
  toc_breaker_model u_brk (.i_clk(clk), .i_coil(tr_a), .i_stall(stall), .i_close(cls),
    .o_aux(brk));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    check_count++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  // expected alarm energisation: healthy power and no failed self-test
  function automatic logic healthy_exp(input logic p, input logic s);
    healthy_exp = p & !s;
  endfunction
  // expected physical inputs: five single-ended, sixth needs both terminals
  function automatic logic [5:0] phys_exp(input logic [5:0] p, input logic n);
    phys_exp = {p[5] & n, p[4:0]};
  endfunction
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fire(input int e);
    flags = 9'h001 << e;
    tick(1);
    flags = 9'h000;
    tick(1);
  endtask
  // flags stay low around a load so the mask change is unambiguous
  task automatic set_mask(input logic [8:0] v);
    mask = v;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    tick(1);
  endtask
  task automatic reclose;
    cls = 1'b1;
    tick(1);
    cls = 1'b0;
    tick(4);
  endtask
  // main sequence
  initial begin
    void'($urandom(26));
    {load, mdt, jmp, stf, neg, stall, cls} = 7'h00;
    {pok, rst, flags, mask, pins, fel, func, cur, cfg} = '0;
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      {pok, stf, neg, pins, fel} = 15'($urandom());
      tick(4);
      check(a_no, healthy_exp(pok, stf));
      check(a_nc, !healthy_exp(pok, stf));
      check(phys, phys_exp(pins, neg));
      check(fen, fel);
    end
    $display("test health_and_pins done");
    for (int e = 0; e < 9; e++) begin
      jmp = e[0];
      cur = '0;
      reclose();
      set_mask(9'($urandom()) & ~(9'h001 << e));
      fire(e);
      check({tr_a, tr_c}, {1'b0, jmp});
      set_mask(9'h1FF);
      fire(e);
      check({tr_a, tr_c}, {1'b1, !jmp});
      cur.phase_le_90 = 3'($urandom_range(0, 6));
      tick(20);
      check(tr_a, 1'b1);
      cur.phase_le_90 = 3'h7;
      tick(3);
      check(tr_a, 1'b1);
      cur.below_5pct = 1'b1;
      tick(2);
      check(tr_a, 1'b0);
    end
    $display("test element_trip done");
    {mdt, stall, jmp, cur} = {3'h6, 4'h0};
    reclose();
    fire(0);
    tick(5);
    check(tr_a, 1'b1);
    cur.phase_le_90 = 3'h7;
    {seen, fall} = '0;
    for (int i = 1; i <= 45; i++) begin
      tick(1);
      if (oi === 1'b1) seen = 1'b1;
      if (tr_a === 1'b0 && fall == 0) fall = i;
    end
    check(seen, 1'b1);
    check(fall >= 3 * CPP && fall <= 3 * CPP + 8, 1'b1);
    // a brief current rise during the wait must restart the three cycles
    cur.phase_le_90 = 3'h0;
    fire(0);
    cur.phase_le_90 = 3'h7;
    tick(20);
    cur.phase_le_90 = 3'h6;
    tick(1);
    cur.phase_le_90 = 3'h7;
    tick(20);
    check(tr_a, 1'b1);
    tick(20);
    check(tr_a, 1'b0);
    $display("test multi_device done");
    {mdt, stall} = 2'h0;
    for (int k = 0; k < 6; k++) begin
      m = 16'($urandom()) | (16'h0001 << k);
      nc = 1'($urandom());
      cfg = '0;
      cfg[k] = '{map: m, use_and: k[0], norm_closed: nc, delay: 15'h0005};
      hv = k[0] ? m : (m & (~m + 16'h0001));
      mv = k[0] ? ~(m & (~m + 16'h0001)) : ~m;
      func = mv;
      tick(20);
      check(outc, 6'(nc) << k);
      // two windows of three ticks each: only a missing restart reaches five
      func = hv;
      tick(12);
      func = mv;
      tick(1);
      func = hv;
      tick(12);
      check(outc[k], nc);
      tick(14);
      check(outc, 6'(!nc) << k);
      func = 16'h0000;
      tick(3);
      check(outc[k], nc);
    end
    $display("test prog_outputs done");
    close_out();
  end
endmodule // toc_top_tb

// *** verif/toc_trip_monitor.sv ***
/*
  toc_trip_monitor: port assertions for the trip output contact logic.
  Assumes mode and configuration ports stay static between resets.
*/
`timescale 1ns/1ps
module toc_trip_monitor #(
  parameter int CYC_PER_POWER = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [toc_pkg::TOC_NUM_ELEM-1:0] i_elem_flags,
  input wire logic [toc_pkg::TOC_NUM_ELEM-1:0] i_elem_mask,
  input wire logic i_mask_load,
  input wire toc_pkg::toc_current_t i_current,
  input wire toc_pkg::toc_breaker_t i_breaker,
  input wire logic i_multi_dev_mode,
  input wire logic i_power_ok,
  input wire logic i_selftest_fail,
  input wire logic o_trip_active,
  input wire logic o_open_interval_start,
  input wire logic o_alarm_no,
  input wire logic o_alarm_nc
);
  localparam int MDT_CYC = 3 * CYC_PER_POWER;
  logic [toc_pkg::TOC_NUM_ELEM-1:0] mask;
  logic [2:0] age;
  int low_cnt;
  logic hit, low, shut, nrm, healthy;
  // decoded conditions; breaker open needs both aux contacts agreeing
  assign hit = |(i_elem_flags & mask);
  assign low = &i_current.phase_le_90;
  assign shut = !i_breaker.breaker_closed_aux && i_breaker.breaker_open_aux;
  assign nrm = !i_multi_dev_mode;
  assign healthy = i_power_ok && !i_selftest_fail;
  // mirror of the element mask
  always_ff @(posedge i_clk) begin
    if (i_rst) mask <= toc_pkg::TOC_MASK_RST;
    else if (i_mask_load) mask <= i_elem_mask;
  end
  // cycles since reset, saturating; registered outputs need one to refill
  always_ff @(posedge i_clk) begin
    if (i_rst) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  // run of quiet cycles in multi-device mode
  always_ff @(posedge i_clk) begin
    if (i_rst || !(i_multi_dev_mode && low && !hit)) low_cnt <= 0;
    else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_trip_on_elem: assert property (hit |=> o_trip_active)
    else $error("enabled element did not trip");
  a_mask_excludes: assert property (!o_trip_active && !hit |=> !o_trip_active)
    else $error("trip without enabled element");
  a_seal_current: assert property (o_trip_active && !low |=> o_trip_active)
    else $error("trip released with phase current high");
  a_seal_fault: assert property (
    o_trip_active && nrm && !i_current.below_5pct |=> o_trip_active)
    else $error("trip released with fault current");
  a_seal_breaker: assert property (
    o_trip_active && nrm && $past(i_breaker.breaker_closed_aux, 2) |=> o_trip_active)
    else $error("trip released with breaker closed");
  a_normal_drop: assert property (
    o_trip_active && nrm && !hit && low && i_current.below_5pct && shut && $past(shut)
    && $past(shut, 2) && $past(shut, 3) |=> !o_trip_active)
    else $error("trip not released");
  a_mdt_not_early: assert property ($fell(o_trip_active) && !nrm |-> low_cnt >= MDT_CYC)
    else $error("multi-device release too early");
  a_mdt_not_late: assert property (!nrm && low_cnt == MDT_CYC + 8 |-> !o_trip_active)
    else $error("multi-device release too late");
  a_open_cause: assert property (
    o_open_interval_start && !nrm |-> $past(low) && $past(o_trip_active))
    else $error("open interval start without cause");
  a_open_pulse: assert property (o_open_interval_start |=> !o_open_interval_start)
    else $error("open interval start longer than one cycle");
  a_alarm_pair: assert property (
    age > 3'h1 |-> o_alarm_no == $past(healthy) && o_alarm_nc == !o_alarm_no)
    else $error("alarm pair wrong");
  c_normal_drop: cover property (nrm && $fell(o_trip_active));
  c_mdt_drop: cover property (!nrm && $fell(o_trip_active));
  c_open_pulse: cover property (o_open_interval_start);
endmodule // toc_trip_monitor
bind toc_top toc_trip_monitor #(.CYC_PER_POWER(CYC_PER_POWER)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_elem_flags(i_elem_flags), .i_elem_mask(i_elem_mask),
  .i_mask_load(i_mask_load), .i_current(i_current), .i_breaker(i_breaker),
  .i_multi_dev_mode(i_multi_dev_mode), .i_power_ok(i_power_ok),
  .i_selftest_fail(i_selftest_fail), .o_trip_active(o_trip_active),
  .o_open_interval_start(o_open_interval_start), .o_alarm_no(o_alarm_no),
  .o_alarm_nc(o_alarm_nc));
